//--- logic/tcw_rule_cache_writer.sv
// Staging cache and commit controller for the ternary rule memories
`timescale 1ns/1ps
`default_nettype none
// Function
// - First lookup owns addresses 1024 to 3071
// - Each address holds 36 entry/mask bits
// - Each address holds 70 action bits
// - Unused top entry bits act as match-zero
// - Cache frozen while update in progress
// - Cache clear resets entry, mask, action, counter
// - Cleared cache holds match-off entry, zero action
// - Command four plus address commits and sets busy
// - Busy clears only after memory write completes
// - Cache words are indexed 32-bit words
// - Egress memory owns addresses 0 to 511
// - Egress rule: 30-bit entry, 285-bit action
// - Four-address action 280 bits over four offsets
// - Eleven egress default rules at 512 plus n
module tcw_rule_cache_writer
    import tcw_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    // Cache word access
    input  wire logic                      cache_wr_en,
    input  wire logic                      cache_rd_en,
    input  wire logic [1:0]                cache_sel,
    input  wire logic [CACHE_IDX_W-1:0]    cache_index,
    input  wire logic [31:0]               cache_wdata,
    output logic      [31:0]               cache_rdata,
    output logic                           cache_refused,
    // Rule valid bit
    input  wire logic                      rule_valid_wr,
    input  wire logic                      rule_valid_in,
    output logic                           rule_valid,
    // Update control
    input  wire logic                      clear_cache,
    input  wire logic                      update_wr,
    input  wire logic [31:0]               update_value,
    input  wire logic                      lookup_select,
    output logic                           update_in_progress,
    output logic                           update_refused,
    output logic                           update_done,
    // Classification lookup read port
    input  wire logic                      class_look_en,
    input  wire logic [RULE_ADDR_W-1:0]    class_look_addr,
    output logic      [CLASS_WORD_W-1:0]   class_look_word,
    // Egress lookup read port
    input  wire logic                      egr_look_en,
    input  wire logic                      egr_look_default,
    input  wire logic [3:0]                egr_look_index,
    input  wire logic [EGR_AW-1:0]         egr_look_addr,
    output logic      [EGR_WORD_W-1:0]     egr_look_word
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [CLASS_AW-1:0] class_offset(input logic [RULE_ADDR_W-1:0] a);
        logic [RULE_ADDR_W-1:0] d;
        d = a - CLASS_LO;
        return d[CLASS_AW-1:0];
    endfunction

    function automatic logic index_ok(input logic [1:0] sel, input logic [CACHE_IDX_W-1:0] idx);
        logic ok;
        ok = 1'b0;
        case (sel)
            SEL_ENTRY, SEL_MASK: ok = (int'(idx) < ENTRY_WORDS);
            SEL_ACTION:          ok = (int'(idx) < ACTION_WORDS);
            default:             ok = (idx == '0);
        endcase
        return ok;
    endfunction

    // ************************************************************
    // Cache storage
    // ************************************************************
    logic [31:0]             entry_cache  [0:ENTRY_WORDS-1];
    logic [31:0]             mask_cache   [0:ENTRY_WORDS-1];
    logic [31:0]             action_cache [0:ACTION_WORDS-1];
    logic                    counter_cache;
    tcw_state_type           state;
    logic [RULE_ADDR_W-1:0]  target_addr;
    logic                    target_egress;
    logic [2:0]              cmd_field;
    logic [RULE_ADDR_W-1:0]  addr_field;
    logic                    addr_ok;
    logic                    accept;
    logic                    cache_wr_ok;
    logic [63:0]             entry_flat;
    logic [63:0]             mask_flat;
    logic [287:0]            action_flat;
    logic [CLASS_WORD_W-1:0] class_wr_data;
    logic [EGR_WORD_W-1:0]   egr_wr_data;
    logic                    class_wr_en;
    logic                    egr_wr_en;
    logic [EGR_AW-1:0]       egr_rd_addr;

    // Command decode; address sits above the command field
    assign cmd_field  = update_value[CMD_W-1:0];
    assign addr_field = update_value[ADDR_SHIFT +: RULE_ADDR_W];
    // Egress range runs through the last default rule, so defaults stay writable
    assign addr_ok    = lookup_select
                      ? (addr_field <= {2'b00, EGR_DEFAULT_BASE} + {8'h00, EGR_DEFAULT_NUM} - 12'h001)
                      : (addr_field >= CLASS_LO) && (addr_field <= CLASS_HI);
    assign accept      = update_wr && !update_in_progress && (cmd_field == CMD_WRITE) && addr_ok;
    assign cache_wr_ok = cache_wr_en && !update_in_progress && index_ok(cache_sel, cache_index);

    // Entry, mask and action words; clear first so a later word write in the same cycle lands
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < ENTRY_WORDS; i++) begin
                entry_cache[i] <= CLEAR_ENTRY;
                mask_cache[i]  <= CLEAR_MASK;
            end
            for (int i = 0; i < ACTION_WORDS; i++) begin
                action_cache[i] <= CLEAR_ACTION;
            end
            counter_cache <= CLEAR_COUNTER;
        end else if (!update_in_progress) begin
            if (clear_cache) begin
                for (int i = 0; i < ENTRY_WORDS; i++) begin
                    entry_cache[i] <= CLEAR_ENTRY;
                    mask_cache[i]  <= CLEAR_MASK;
                end
                for (int i = 0; i < ACTION_WORDS; i++) begin
                    action_cache[i] <= CLEAR_ACTION;
                end
                counter_cache <= CLEAR_COUNTER;
            end
            if (cache_wr_ok) begin
                case (cache_sel)
                    SEL_ENTRY:  entry_cache[cache_index[0]]  <= cache_wdata;
                    SEL_MASK:   mask_cache[cache_index[0]]   <= cache_wdata;
                    SEL_ACTION: action_cache[cache_index]    <= cache_wdata;
                    default:    counter_cache                <= cache_wdata[0];
                endcase
            end
        end
    end

    // Rule valid is not part of the clear, it is set per rule
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rule_valid <= RESET_VALID;
        end else if (rule_valid_wr && !update_in_progress) begin
            rule_valid <= rule_valid_in;
        end
    end

    // Registered cache readback, reads do not disturb a commit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cache_rdata <= '0;
        end else if (cache_rd_en) begin
            if (!index_ok(cache_sel, cache_index)) begin
                cache_rdata <= '0;
            end else if (cache_sel == SEL_ENTRY) begin
                cache_rdata <= entry_cache[cache_index[0]];
            end else if (cache_sel == SEL_MASK) begin
                cache_rdata <= mask_cache[cache_index[0]];
            end else if (cache_sel == SEL_ACTION) begin
                cache_rdata <= action_cache[cache_index];
            end else begin
                cache_rdata <= {31'h0000_0000, counter_cache};
            end
        end
    end

    // Refusal pulses
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cache_refused  <= 1'b0;
            update_refused <= 1'b0;
        end else begin
            cache_refused  <= (cache_wr_en && !cache_wr_ok) || (rule_valid_wr && update_in_progress);
            update_refused <= update_wr && !accept;
        end
    end

    // ************************************************************
    // Commit sequencer
    // ************************************************************
    // Busy stays up across the write and one settle cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state              <= ST_IDLE;
            update_in_progress <= 1'b0;
            update_done        <= 1'b0;
            target_addr        <= '0;
            target_egress      <= 1'b0;
        end else begin
            update_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state              <= ST_WRITE;
                        update_in_progress <= 1'b1;
                        target_addr        <= addr_field;
                        target_egress      <= lookup_select;
                    end
                end
                ST_WRITE: begin
                    state <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    state              <= ST_IDLE;
                    update_in_progress <= 1'b0;
                    update_done        <= 1'b1;
                end
                default: begin
                    state              <= ST_IDLE;
                    update_in_progress <= 1'b0;
                end
            endcase
        end
    end

    // Pack the cache into each memory's row; widths cut the zero-extended top words
    assign entry_flat    = {entry_cache[1], entry_cache[0]};
    assign mask_flat     = {mask_cache[1], mask_cache[0]};
    assign action_flat   = {action_cache[8], action_cache[7], action_cache[6], action_cache[5], action_cache[4],
                            action_cache[3], action_cache[2], action_cache[1], action_cache[0]};
    assign class_wr_data = {counter_cache, action_flat[CLASS_ACTION_W-1:0],
                            mask_flat[CLASS_ENTRY_W-1:0], entry_flat[CLASS_ENTRY_W-1:0]};
    assign egr_wr_data   = {rule_valid, counter_cache, action_flat[EGR_ACTION_W-1:0],
                            mask_flat[EGR_ENTRY_W-1:0], entry_flat[EGR_ENTRY_W-1:0]};
    assign class_wr_en   = (state == ST_WRITE) && !target_egress;
    assign egr_wr_en     = (state == ST_WRITE) && target_egress;
    assign egr_rd_addr   = egr_look_default ? EGR_DEFAULT_BASE + {6'h00, egr_look_index} : egr_look_addr;

    // ************************************************************
    // Rule memories
    // ************************************************************
    tcw_rule_mem #(
        .WIDTH (CLASS_WORD_W),
        .DEPTH (CLASS_DEPTH),
        .AW    (CLASS_AW)
    ) u_class_mem (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .wr_en   (class_wr_en),
        .wr_addr (class_offset(target_addr)),
        .wr_data (class_wr_data),
        .rd_en   (class_look_en),
        .rd_addr (class_offset(class_look_addr)),
        .rd_data (class_look_word)
    );

    tcw_rule_mem #(
        .WIDTH (EGR_WORD_W),
        .DEPTH (EGR_DEPTH),
        .AW    (EGR_AW)
    ) u_egr_mem (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .wr_en   (egr_wr_en),
        .wr_addr (target_addr[EGR_AW-1:0]),
        .wr_data (egr_wr_data),
        .rd_en   (egr_look_en),
        .rd_addr (egr_rd_addr),
        .rd_data (egr_look_word)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    a_commit_sets_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        accept |=> update_in_progress && (state == ST_WRITE) && (target_addr == $past(addr_field)))
        else $error("accepted commit did not raise busy");

    a_busy_clears_late: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(update_in_progress) |-> update_in_progress [*2] ##1 !update_in_progress)
        else $error("busy flag length wrong");

    a_write_inside_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (class_wr_en || egr_wr_en) |-> update_in_progress ##1 update_in_progress)
        else $error("memory write outside busy window");

    a_cache_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
        update_in_progress |=> $stable(entry_flat) && $stable(mask_flat) && $stable(action_flat))
        else $error("cache changed while busy");

    a_busy_refuses: assert property (@(posedge sys_clk) disable iff (!rst_b)
        update_wr && update_in_progress |=> update_refused && (state != ST_WRITE))
        else $error("command during busy not refused");

    a_clear_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clear_cache && !update_in_progress && !cache_wr_en
        |=> (entry_flat == {2{CLEAR_ENTRY}}) && (mask_flat == {2{CLEAR_MASK}}) && (action_flat == '0) && !counter_cache)
        else $error("cache clear incomplete");

    a_clear_then_commit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clear_cache && accept && !cache_wr_en && !lookup_select
        |=> class_wr_en && (class_wr_data[CLASS_WORD_W-2:2*CLASS_ENTRY_W] == '0))
        else $error("commit copied cache before clear");

    a_class_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
        class_wr_en |-> (target_addr >= CLASS_LO) && (target_addr <= CLASS_HI))
        else $error("classification write outside owned range");

    a_egress_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
        egr_wr_en |-> (target_addr <= EGR_HI)
                   || ((target_addr >= {2'b00, EGR_DEFAULT_BASE})
                   && (target_addr < {2'b00, EGR_DEFAULT_BASE} + {8'h00, EGR_DEFAULT_NUM})))
        else $error("egress write outside memory");

    a_done_after_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(update_in_progress) |-> update_done && (state == ST_IDLE))
        else $error("done pulse not with busy release");
endmodule // tcw_rule_cache_writer
`default_nettype wire

//--- logic/tcw_pkg.sv
// Shared constants and types for the rule cache writer
package tcw_pkg;
    // ************************************************************
    // Cache geometry
    // ************************************************************
    localparam int          CACHE_DATA_W  = 32;
    localparam int          ENTRY_WORDS   = 2;
    localparam int          ACTION_WORDS  = 9;
    localparam int          CACHE_IDX_W   = 4;
    localparam logic [31:0] CLEAR_ENTRY   = 32'hffff_ffff;
    localparam logic [31:0] CLEAR_MASK    = 32'hffff_ffff;
    localparam logic [31:0] CLEAR_ACTION  = 32'h0000_0000;
    localparam logic        CLEAR_COUNTER = 1'h0;
    localparam logic        RESET_VALID   = 1'h0;

    // ************************************************************
    // Rule widths per address
    // ************************************************************
    localparam int CLASS_ENTRY_W  = 36;
    localparam int CLASS_ACTION_W = 70;
    localparam int EGR_ENTRY_W    = 30;
    localparam int EGR_ACTION_W   = 285;
    localparam int CLASS_WORD_W   = 2 * CLASS_ENTRY_W + CLASS_ACTION_W + 1;
    localparam int EGR_WORD_W     = 2 * EGR_ENTRY_W + EGR_ACTION_W + 2;

    // ************************************************************
    // Address map of the rule memories
    // ************************************************************
    localparam int           RULE_ADDR_W      = 12;
    localparam int           CLASS_AW         = 11;
    localparam int           EGR_AW           = 10;
    localparam logic [11:0]  CLASS_LO         = 12'h400;
    localparam logic [11:0]  CLASS_HI         = 12'hbff;
    localparam int           CLASS_DEPTH      = 2048;
    localparam logic [11:0]  EGR_HI           = 12'h1ff;
    localparam logic [9:0]   EGR_DEFAULT_BASE = 10'h200;
    localparam logic [3:0]   EGR_DEFAULT_NUM  = 4'hb;
    localparam int           EGR_DEPTH        = 523;

    // ************************************************************
    // Update control word layout
    // ************************************************************
    localparam int         CMD_W      = 3;
    localparam int         ADDR_SHIFT = 3;
    localparam logic [2:0] CMD_WRITE  = 3'h4;

    typedef enum logic [1:0] {
        SEL_ENTRY   = 2'b00,
        SEL_MASK    = 2'b01,
        SEL_ACTION  = 2'b10,
        SEL_COUNTER = 2'b11
    } tcw_sel_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WRITE  = 2'b01,
        ST_SETTLE = 2'b10
    } tcw_state_type;
endpackage

//--- logic/tcw_rule_mem.sv
// Single-port-write rule memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tcw_rule_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] store [0:DEPTH-1];

    // Array has no reset; software initialises every rule it uses
    always_ff @(posedge sys_clk) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            store[wr_addr] <= wr_data;
        end
    end

    // Registered read so lookups see a clean flop output
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (rd_en && (int'(rd_addr) < DEPTH)) begin
            rd_data <= store[rd_addr];
        end
    end
endmodule // tcw_rule_mem
`default_nettype wire

//--- tb/tcw_rule_cache_writer_test.sv
// Self-checking bench for the rule cache writer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tcw_rule_cache_writer_test
    import tcw_pkg::*;
;
    // Ports of the block under test
    logic                    sys_clk, rst_b, cache_wr_en, cache_rd_en, cache_refused, rule_valid_wr, rule_valid_in;
    logic                    rule_valid, clear_cache, update_wr, lookup_select, update_in_progress, update_refused;
    logic                    update_done, class_look_en, egr_look_en, egr_look_default;
    logic [1:0]              cache_sel;
    logic [CACHE_IDX_W-1:0]  cache_index;
    logic [3:0]              egr_look_index;
    logic [31:0]             cache_wdata, cache_rdata, update_value;
    logic [RULE_ADDR_W-1:0]  class_look_addr;
    logic [EGR_AW-1:0]       egr_look_addr;
    logic [CLASS_WORD_W-1:0] class_look_word;
    logic [EGR_WORD_W-1:0]   egr_look_word;
    int                      num_errors = 0;
    int                      total_checks = 0;

    tcw_rule_cache_writer dut (
        .sys_clk, .rst_b, .cache_wr_en, .cache_rd_en, .cache_sel, .cache_index, .cache_wdata, .cache_rdata,
        .cache_refused, .rule_valid_wr, .rule_valid_in, .rule_valid, .clear_cache, .update_wr, .update_value,
        .lookup_select, .update_in_progress, .update_refused, .update_done, .class_look_en, .class_look_addr,
        .class_look_word, .egr_look_en, .egr_look_default, .egr_look_index, .egr_look_addr, .egr_look_word
    );

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    // ************************************************************
    // Port tasks
    // ************************************************************
    // Inputs move 1 ns after the edge, so they never race the sampling edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] s, input logic [3:0] i, input logic [31:0] d);
        tick();
        {cache_wr_en, cache_sel, cache_index, cache_wdata} = {1'b1, s, i, d};
        tick();
        cache_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [1:0] s, input logic [3:0] i, input logic [31:0] e);
        tick();
        {cache_rd_en, cache_sel, cache_index} = {1'b1, s, i};
        tick();
        cache_rd_en = 1'b0;
        `CHK(cache_rdata, e)
    endtask
    task automatic clr();
        tick();
        clear_cache = 1'b1;
        tick();
        clear_cache = 1'b0;
    endtask
    // Busy stands two cycles, done pulses once with its fall
    task automatic commit(input logic ls, input logic [11:0] a, input logic [2:0] c, input logic ok);
        tick();
        {update_wr, lookup_select, update_value} = {1'b1, ls, 17'h0, a, c};
        tick();
        update_wr = 1'b0;
        `CHK({update_in_progress, update_refused}, {ok, ~ok})
        if (ok) begin
            tick();
            `CHK({update_in_progress, update_done}, 2'b10)
            tick();
            `CHK({update_in_progress, update_done}, 2'b01)
            tick();
            `CHK(update_done, 1'b0)
        end
    endtask
    task automatic lc(input logic [11:0] a, input logic [CLASS_WORD_W-1:0] e);
        tick();
        {class_look_en, class_look_addr} = {1'b1, a};
        tick();
        class_look_en = 1'b0;
        `CHK(class_look_word, e)
    endtask
    task automatic le(input logic d, input logic [3:0] i, input logic [9:0] a, input logic [EGR_WORD_W-1:0] e);
        tick();
        {egr_look_en, egr_look_default, egr_look_index, egr_look_addr} = {1'b1, d, i, a};
        tick();
        egr_look_en = 1'b0;
        `CHK(egr_look_word, e)
    endtask
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset contents, then out-of-range words are refused
    task automatic t_reset();
        `CHK({update_in_progress, update_done, rule_valid}, 3'b000)
        rd(SEL_ENTRY, 4'h1, 32'hffff_ffff);
        rd(SEL_ACTION, 4'h8, 32'h0);
        wr(SEL_ACTION, 4'h9, 32'h1);
        `CHK(cache_refused, 1'b1)
        rd(SEL_ENTRY, 4'h2, 32'h0);
    endtask
    // Four-offset rule, top offset first, cache cleared per offset
    task automatic t_wide();
        logic [31:0]             a0, ew0;
        logic [CLASS_WORD_W-1:0] row [4];
        for (int o = 3; o >= 0; o--) begin
            a0 = (32'h1357_9bd0 << o) | (o == 0 ? 32'h4 : 32'h0);
            ew0 = 32'h2468_ace0 | (o == 0 ? 32'h2 : 32'h0);
            clr();
            wr(SEL_ACTION, 4'h0, a0);
            if (o == 3) wr(SEL_ACTION, 4'h1, 32'h7fff);
            if (o == 3) wr(SEL_COUNTER, 4'h0, 32'h1);
            if (o == 2) wr(SEL_ACTION, 4'h2, 32'h3f);
            if (o < 2) begin
                wr(SEL_ENTRY, 4'h0, ew0);
                wr(SEL_ENTRY, 4'h1, 32'hfff0 | 32'(o + 5));
                wr(SEL_MASK, 4'h0, 32'h0f0f_0f00);
                wr(SEL_MASK, 4'h1, 32'h0);
            end
            row[o] = {o == 3, o == 2 ? 6'h3f : 6'h0, o == 3 ? 32'h7fff : 32'h0, a0,
                      o < 2 ? {4'h0, 32'h0f0f_0f00} : {36{1'b1}}, o < 2 ? {4'(o + 5), ew0} : {36{1'b1}}};
            commit(1'b0, 12'(1412 + o), 3'h4, 1'b1);
        end
        for (int o = 0; o < 4; o++) lc(12'(1412 + o), row[o]);
    endtask
    // Cache frozen and commands refused while busy
    task automatic t_busy();
        wr(SEL_ACTION, 4'h0, 32'h11);
        tick();
        {update_wr, lookup_select, update_value} = {1'b1, 1'b0, 17'h0, 12'd2000, 3'h4};
        tick();
        {clear_cache, cache_wr_en, cache_sel, cache_index, cache_wdata} = {2'b11, SEL_ACTION, 4'h0, 32'hffff};
        tick();
        {clear_cache, cache_wr_en, update_wr} = 3'b000;
        `CHK({cache_refused, update_refused, update_in_progress}, 3'b111)
        tick();
        `CHK({update_in_progress, update_done}, 2'b01)
        rd(SEL_ACTION, 4'h0, 32'h11);
    endtask
    // Address ranges and command codes
    task automatic t_range();
        commit(1'b0, 12'd1023, 3'h4, 1'b0);
        commit(1'b0, 12'd1024, 3'h4, 1'b1);
        commit(1'b0, 12'd3071, 3'h4, 1'b1);
        commit(1'b0, 12'd3072, 3'h4, 1'b0);
        commit(1'b1, 12'd0, 3'h4, 1'b1);
        commit(1'b1, 12'd511, 3'h4, 1'b1);
        commit(1'b1, 12'd522, 3'h4, 1'b1);
        commit(1'b1, 12'd523, 3'h4, 1'b0);
        for (int c = 0; c < 8; c++) commit(1'b0, 12'd1500, 3'(c), c == 4);
    endtask
    // Egress rule with valid bit, also placed as default rule 3
    task automatic t_egress();
        logic [287:0] act;
        clr();
        for (int i = 0; i < 9; i++) begin
            act[i*32 +: 32] = 32'h0101_0101 * 32'(i + 1);
            wr(SEL_ACTION, 4'(i), act[i*32 +: 32]);
        end
        wr(SEL_ENTRY, 4'h0, 32'h3abc_1234);
        wr(SEL_MASK, 4'h0, 32'h0000_00ff);
        tick();
        {rule_valid_wr, rule_valid_in} = 2'b11;
        tick();
        rule_valid_wr = 1'b0;
        `CHK(rule_valid, 1'b1)
        commit(1'b1, 12'd215, 3'h4, 1'b1);
        commit(1'b1, 12'd515, 3'h4, 1'b1);
        le(1'b0, 4'h0, 10'd215, {2'b10, act[284:0], 30'h0ff, 30'h3abc_1234});
        le(1'b1, 4'h3, 10'd0, {2'b10, act[284:0], 30'h0ff, 30'h3abc_1234});
    endtask
    // Clear lands before a same-cycle commit or word write
    task automatic t_clear();
        wr(SEL_ACTION, 4'h0, 32'hdead_beef);
        tick();
        // Deletes offset 0 of the wide rule by committing a cleared cache over it
        {clear_cache, update_wr, lookup_select, update_value} = {3'b110, 17'h0, 12'd1412, 3'h4};
        tick();
        {clear_cache, update_wr} = 2'b00;
        tick();
        tick();
        `CHK(update_done, 1'b1)
        lc(12'd1412, {71'h0, {72{1'b1}}});
        tick();
        {clear_cache, cache_wr_en, cache_sel, cache_index, cache_wdata} = {2'b11, SEL_MASK, 4'h1, 32'h6};
        tick();
        {clear_cache, cache_wr_en} = 2'b00;
        rd(SEL_MASK, 4'h1, 32'h6);
        rd(SEL_ACTION, 4'h0, 32'h0);
    endtask

    // Main sequence: reset held 12 cycles
    initial begin
        {sys_clk, rst_b, cache_wr_en, cache_rd_en, cache_sel, cache_index, cache_wdata} = '0;
        {rule_valid_wr, rule_valid_in, clear_cache, update_wr, update_value, lookup_select} = '0;
        {class_look_en, class_look_addr, egr_look_en, egr_look_default, egr_look_index, egr_look_addr} = '0;
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        t_reset();
        t_wide();
        t_busy();
        t_range();
        t_egress();
        t_clear();
        finish_test();
    end

    // Watchdog: the run needs well under 2000 cycles
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
endmodule // tcw_rule_cache_writer_test
`default_nettype wire
